// File: cgpd_defs.svh
// Purpose: constants for the clock gating and power-down block
// Assumes: 32-bit register port, byte offsets
// Notes: peripheral order is dma, pci, serial, timer, parallel io, codec link
`ifndef CGPD_DEFS_SVH
`define CGPD_DEFS_SVH
`define CGPD_NPERIPH 6
`define CGPD_OFS_GATE 8'h00
`define CGPD_OFS_CHIPCFG 8'h04
`define CGPD_OFS_CORECFG 8'h08
`define CGPD_OFS_STATUS 8'h0c
`define CGPD_GATE_EN_LSB 0
`define CGPD_GATE_RST_LSB 16
`define CGPD_GATE_RESET 32'h003f0000
`define CGPD_GATE_WMASK 32'h003f003f
`define CGPD_CORECFG_HALT_BIT 0
`define CGPD_CORECFG_RESET 32'h00000001
`define CGPD_CORECFG_WMASK 32'h00000001
`define CGPD_DIVSEL_LSB 0
`define CGPD_DIVSEL_LOW_RESET 1'b0
`endif

// File: cgpd_pkg.sv
// Purpose: types for the clock gating and power-down block
// Assumes: none
// Notes: gray codes along run, sleep, wake
package cgpd_pkg;
	typedef enum logic [1:0] {
		CGPD_RUN = 2'b00,
		CGPD_SLEEP = 2'b01,
		CGPD_WAKE = 2'b11
	} cgpd_state_t;
endpackage

// File: cgpd_props.sv
// Purpose: port checks for the clock gating and power-down block
// Assumes: bound into cgpd_top, sees its ports only
// Notes: one clock; gate_on_a and gate_hold_a sample on the falling edge, gate_low_a on the rising edge
`timescale 1ns/10ps
module cgpd_props (
	input logic clock, // system clock
	input logic resetn, // chip reset, active low
	input logic [7:0] addr, // register address
	input logic [31:0] wdata, // register write data
	input logic wr, // write strobe
	input logic wait_exec, // wait instruction pulse
	input logic irq_exception, // interrupt pin
	input logic core_run, // core executing
	input logic core_halt, // halt flag
	input logic core_doze, // doze flag
	input logic [5:0] periph_clock, // gated clocks
	input logic [5:0] periph_resetn // module resets, active low
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence wk; !core_run ##1 core_run; endsequence
	gate_low_a: assert property (periph_clock == 6'h00) else $error("gclk");
	gate_on_a: assert property (@(negedge clock) wr && addr == 8'h00 |-> ##2
		periph_clock == $past(wdata[5:0], 2)) else $error("gate");
	mod_rst_a: assert property (wr && addr == 8'h00 |=> periph_resetn == ~$past(wdata[21:16]))
		else $error("mrst");
	sleep_in_a: assert property (core_run && wait_exec && !$past(irq_exception, 2) |=> core_halt != core_doze)
		else $error("in");
	hold_a: assert property ((core_halt | core_doze) && !$past(irq_exception, 2) |=> $stable(core_halt))
		else $error("hold");
	wake_a: assert property ((core_halt | core_doze) && $past(irq_exception, 2) |=> wk) else $error("wake");
	enter_a: assert property ($rose(core_halt | core_doze) |-> $past(wait_exec)) else $error("cause");
	run_one_a: assert property (core_run |-> !core_halt && !core_doze) else $error("run");
	gate_hold_a: assert property (@(negedge clock) !($past(wr, 2) && $past(addr, 2) == 8'h00) |->
		$stable(periph_clock)) else $error("gate moved");
endmodule
bind cgpd_top cgpd_props cgpd_props_i (
	.clock(clock),
	.resetn(resetn),
	.addr(addr),
	.wdata(wdata),
	.wr(wr),
	.wait_exec(wait_exec),
	.irq_exception(irq_exception),
	.core_run(core_run),
	.core_halt(core_halt),
	.core_doze(core_doze),
	.periph_clock(periph_clock),
	.periph_resetn(periph_resetn)
);

// File: cgpd_top.sv
// Purpose: core low-power entry and exit, per-peripheral clock gating and module resets, divider strap capture
// Assumes: single 100 MHz clock; boot straps and interrupt request come from pins
// Notes: gated clocks are made with a latch-free low-phase enable register
// Notes on behaviour
// - upper two divider select bits load from straps on address pins 11 and 10.
// - wait instruction puts the core to halt or doze and stops execution.
// - core leaves halt or doze only on a taken interrupt exception.
// - halt-select bit in core configuration picks halt or doze.
// - dma, pci, serial, timer, parallel io and codec link clocks stop individually.
// - each peripheral clock has its own on/off bit.
// - each gateable module has its own reset bit, active while set.
// - module reset returns its registers to reset values.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "cgpd_defs.svh"
module cgpd_top (
	input wire logic clock, // 100 MHz system clock
	input wire logic resetn, // asynchronous reset, active low
	input wire logic [7:0] addr, // register byte address
	input wire logic [31:0] wdata, // register write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata, // read data, one cycle after rd
	input wire logic [1:0] boot_addr_11_10, // strap pins address 11 and 10
	input wire logic wait_exec, // core executes wait instruction, one-cycle pulse
	input wire logic irq_exception, // interrupt exception request from pin
	output logic core_run, // core may execute instructions
	output logic core_halt, // core in halt state
	output logic core_doze, // core in doze state, snooping kept
	output logic [5:0] periph_clock, // gated peripheral clocks
	output logic [5:0] periph_resetn // peripheral module resets, active low
);
	localparam int N = `CGPD_NPERIPH;
	logic [31:0] peripheral_clock_gate_register;
	logic [31:0] core_config;
	logic [2:0] pci_clock_divider_select;
	logic [1:0] strap_s1, strap_s2;
	logic irq_s1, irq_s2;
	logic strap_taken;
	logic halt_sel;
	logic next_core_halt;
	logic next_core_doze;
	logic [N-1:0] gate_en;
	cgpd_pkg::cgpd_state_t state, next_state;

	// one write decode, shared by every writable register
	function automatic logic reg_write_hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
		return strobe && (a == ofs);
	endfunction

	// status word: live gate enables above the two sleep flags
	function automatic logic [31:0] status_word(input logic [5:0] en, input logic doze, input logic halt);
		return {24'h0, en, doze, halt};
	endfunction

	// strap flops have no reset, so they fill from the pins while resetn is low
	always_ff @(posedge clock) begin
		strap_s1 <= boot_addr_11_10;
		strap_s2 <= strap_s1;
	end

	// two-stage synchroniser for the interrupt pin
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irq_s1 <= 1'b0;
			irq_s2 <= 1'b0;
		end else begin
			irq_s1 <= irq_exception;
			irq_s2 <= irq_s1;
		end
	end

	// capture flag: set at the first edge after reset release
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strap_taken <= 1'b0;
		end else begin
			strap_taken <= 1'b1;
		end
	end

	// strap divider capture
	// later writes from software override the strap value
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pci_clock_divider_select <= 3'h0;
		end else if (!strap_taken) begin
			pci_clock_divider_select <= {strap_s2, `CGPD_DIVSEL_LOW_RESET};
		end else if (reg_write_hit(wr, addr, `CGPD_OFS_CHIPCFG)) begin
			pci_clock_divider_select <= wdata[`CGPD_DIVSEL_LSB +: 3];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			peripheral_clock_gate_register <= `CGPD_GATE_RESET;
		end else if (reg_write_hit(wr, addr, `CGPD_OFS_GATE)) begin
			peripheral_clock_gate_register <= wdata & `CGPD_GATE_WMASK;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			core_config <= `CGPD_CORECFG_RESET;
		end else if (reg_write_hit(wr, addr, `CGPD_OFS_CORECFG)) begin
			core_config <= wdata & `CGPD_CORECFG_WMASK;
		end
	end
	assign halt_sel = core_config[`CGPD_CORECFG_HALT_BIT];

	// wake lasts one cycle so that run restarts from a settled state
	// wait entry
	always_comb begin
		next_state = state;
		unique case (state)
			cgpd_pkg::CGPD_RUN: begin
				if (wait_exec && !irq_s2) begin
					next_state = cgpd_pkg::CGPD_SLEEP;
				end
			end
			cgpd_pkg::CGPD_SLEEP: begin
				if (irq_s2) begin
					next_state = cgpd_pkg::CGPD_WAKE;
				end
			end
			cgpd_pkg::CGPD_WAKE: begin
				next_state = cgpd_pkg::CGPD_RUN;
			end
			default: begin
				next_state = cgpd_pkg::CGPD_RUN;
			end
		endcase
	end

	// sleep flag next values: latched on entry, cleared on leaving sleep
	always_comb begin
		next_core_halt = core_halt;
		next_core_doze = core_doze;
		if (state == cgpd_pkg::CGPD_RUN && next_state == cgpd_pkg::CGPD_SLEEP) begin
			next_core_halt = halt_sel;
			next_core_doze = !halt_sel;
		end else if (next_state != cgpd_pkg::CGPD_SLEEP) begin
			next_core_halt = 1'b0;
			next_core_doze = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= cgpd_pkg::CGPD_RUN;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			core_halt <= 1'b0;
		end else begin
			core_halt <= next_core_halt;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			core_doze <= 1'b0;
		end else begin
			core_doze <= next_core_doze;
		end
	end
	assign core_run = (state == cgpd_pkg::CGPD_RUN);

	// enables move on the falling edge, so a gate change never cuts a high phase
	// low-phase enable update
	always_ff @(negedge clock or negedge resetn) begin
		if (!resetn) begin
			gate_en <= '0;
		end else begin
			gate_en <= peripheral_clock_gate_register[`CGPD_GATE_EN_LSB +: N];
		end
	end

	assign periph_clock = {N{clock}} & gate_en;
	// module resets also follow the chip reset
	// module reset held by its bit
	assign periph_resetn = ~peripheral_clock_gate_register[`CGPD_GATE_RST_LSB +: N] & {N{resetn}};

	// read data stands one cycle after rd, zero otherwise
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata <= 32'h0;
		end else if (rd) begin
			unique case (addr)
				`CGPD_OFS_GATE: begin
					rdata <= peripheral_clock_gate_register;
				end
				`CGPD_OFS_CHIPCFG: begin
					rdata <= {29'h0, pci_clock_divider_select};
				end
				`CGPD_OFS_CORECFG: begin
					rdata <= core_config;
				end
				`CGPD_OFS_STATUS: begin
					rdata <= status_word(gate_en, core_doze, core_halt);
				end
				default: begin
					rdata <= 32'h0;
				end
			endcase
		end else begin
			rdata <= 32'h0;
		end
	end
endmodule

// File: clock_gating_power_down_tb.sv
// Purpose: bench for the clock gating and power-down block
// Assumes: straps stable from time zero
// Notes: register model kept in the gate variable
`timescale 1ns/10ps
module clock_gating_power_down_tb;
	logic clock = 0, resetn = 0, wr = 0, rd = 0, wait_exec = 0, irq_exception = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, lfsr = 32'h1741, gate = 32'h003f0000;
	logic [1:0] boot_addr_11_10 = 2'h2;
	logic core_run, core_halt, core_doze;
	logic [5:0] periph_clock, periph_resetn;
	int err_count = 0, checks_done = 0;
	always #5 clock = ~clock;
	cgpd_top cgpd_top_i (
		.clock(clock),
		.resetn(resetn),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.boot_addr_11_10(boot_addr_11_10),
		.wait_exec(wait_exec),
		.irq_exception(irq_exception),
		.core_run(core_run),
		.core_halt(core_halt),
		.core_doze(core_doze),
		.periph_clock(periph_clock),
		.periph_resetn(periph_resetn)
	);
	function logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input logic [31:0] g, e);
		checks_done++;
		err_count += g !== e;
		if (g !== e) $display("Error %0t mismatch got %h want %h", $time, g, e);
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 0;
		rd <= 0;
		@(negedge clock);
		if (!w) chk(rdata, d);
	endtask
	task end_of_test();
		$display("%0d checks %0d errors", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clock);
		resetn <= 1;
		bus(0, 8'h00, gate);
		bus(0, 8'h04, {boot_addr_11_10, 1'h0});
		bus(0, 8'h08, 32'h1);
		bus(0, 8'h10, 32'h0);
		$display("reset done");
		repeat (6) begin
			lfsr = nxt(lfsr);
			bus(1, 8'h00, gate | 32'h003f0000);
			gate = lfsr & 32'h3f | 32'h003f0000;
			bus(1, 8'h00, gate);
			gate = gate & (lfsr | 32'h3f);
			bus(1, 8'h00, gate);
			bus(0, 8'h0c, {gate[5:0], 2'h0});
			chk({26'h0, periph_resetn}, {26'h0, ~gate[21:16]});
			@(posedge clock);
			#1 chk({26'h0, periph_clock}, {26'h0, gate[5:0]});
			@(negedge clock);
			#1 chk({26'h0, periph_clock}, 32'h0);
			bus(1, 8'h04, lfsr);
			bus(0, 8'h04, lfsr & 32'h7);
		end
		$display("gate done");
		begin : sleep_test
			for (int n = 1; n >= 0; n--) begin
				bus(1, 8'h08, n);
				@(posedge clock) wait_exec <= 1;
				@(posedge clock) wait_exec <= 0;
				repeat (4) @(posedge clock);
				@(negedge clock);
				chk({core_run, core_halt, core_doze}, {1'b0, n[0], !n[0]});
				@(posedge clock) irq_exception <= 1;
				for (int k = 0; k < 9 && core_run !== 1'h1; k++) @(negedge clock);
				chk(core_run, 1'h1);
				if (core_run !== 1'h1) disable sleep_test;
				@(posedge clock) irq_exception <= 0;
				repeat (3) @(posedge clock);
			end
			$display("sleep done");
		end
		end_of_test();
	end
endmodule
